//--- include/iog_defs.svh
// Constants for the I/O expander link, its register map and the host registers
`ifndef IOG_DEFS_SVH
`define IOG_DEFS_SVH

// Pointer bytes that select device registers
`define IOG_PTR_SEQ 8'h02
`define IOG_PTR_LVL 8'h09
`define IOG_PTR_OUT_EN 8'h08
`define IOG_PTR_IN_EN 8'h0a
`define IOG_PTR_OD 8'h0c
`define IOG_PTR_FLT 8'h0d
`define IOG_PTR_RDBACK 8'h60

// Sequence register field positions
`define IOG_SEQ_REP 9
`define IOG_SEQ_TEMP 8
`define IOG_TEMP_IDX 4'h8

// Reset values
`define IOG_REG_RST 16'h0000
`define IOG_PIN_RST 8'h00

// Conversion slot timing
`define IOG_CLK_NS 100
`define IOG_CONV_NS 2000
`define IOG_CONV_W 5
`define IOG_CONV_CYC ((`IOG_CONV_NS + `IOG_CLK_NS - 1) / `IOG_CLK_NS)

// Host register byte offsets and fields
`define IOG_AX_PTR 4'h0
`define IOG_AX_WDATA 4'h4
`define IOG_AX_GO 4'h8
`define IOG_AX_STAT 4'hc
`define IOG_GO_WR 0
`define IOG_GO_RD 1
`define IOG_RESP_OK 2'b00
`define IOG_RESP_ERR 2'b10

`endif

//--- include/iog_pkg.sv
// Types shared by both ends of the I/O expander link
package iog_pkg;
  `include "iog_defs.svh"

  // Host link sequencer states
  typedef enum logic [2:0] {H_IDLE, H_START, H_SEND, H_RECV, H_STOP} iog_hstate_type;

  // Whole state of the device end
  typedef struct packed {
    logic frame; // Inside a transfer
    logic rnw; // Transfer direction, one for read
    logic [1:0] wcnt; // Bytes taken in this write
    logic rsel; // Next read byte is the low one
    logic rvalid; // Read byte on offer
    logic [7:0] rbyte; // Read byte
    logic [7:0] ptr; // Pointer byte
    logic [7:0] msb; // Held high data byte
    logic [15:0] seq; // Conversion sequence
    logic [7:0] out_en; // Output enables
    logic [7:0] in_en; // Input enables
    logic [7:0] od; // Open-drain selects
    logic [7:0] lvl; // Output levels
    logic [7:0] flt; // Float selects
    logic conv_on; // Sequence running
    logic [3:0] conv_ch; // Channel in conversion
    logic [`IOG_CONV_W-1:0] conv_cnt; // Slot timer
  } iog_dev_state_type;

  // Whole state of the host end
  typedef struct packed {
    iog_hstate_type st; // Link sequencer state
    logic rd_op; // Current order is a read
    logic second; // Second frame of a read
    logic [1:0] idx; // Byte index in frame
    logic [7:0] tx; // Byte being sent
    logic [7:0] ptr; // Pointer to use
    logic [15:0] wdata; // Word to write
    logic [15:0] rdata; // Word read back
    logic busy; // Order under way
    logic aw_got; // Write address held
    logic w_got; // Write data held
    logic [3:0] awaddr; // Held write address
    logic [31:0] wdat; // Held write data
    logic [3:0] wstrb; // Held byte strobes
    logic bvalid; // Write answer on offer
    logic [1:0] bresp; // Write answer code
    logic rvalid; // Read answer on offer
    logic [31:0] rdat; // Read answer data
    logic [1:0] rresp; // Read answer code
  } iog_host_state_type;
endpackage : iog_pkg

//--- include/iog_link_if.sv
// Byte-level serial link between the host controller and the I/O device
`timescale 1ns/100ps
interface iog_link_if;
  logic start; // Frame start pulse
  logic start_rnw; // Direction with start
  logic wr_valid; // Byte offered to device
  logic [7:0] wr_byte; // Byte to device
  logic wr_ready; // Device takes the byte
  logic rd_valid; // Byte offered by device
  logic [7:0] rd_byte; // Byte from device
  logic rd_ready; // Host takes the byte
  logic stop; // Frame stop pulse

  modport dev (input start, input start_rnw, input wr_valid, input wr_byte, input rd_ready,
    input stop, output wr_ready, output rd_valid, output rd_byte);
  modport host (output start, output start_rnw, output wr_valid, output wr_byte,
    output rd_ready, output stop, input wr_ready, input rd_valid, input rd_byte);
endinterface : iog_link_if

//--- verilog/iog_next_pick.sv
// Finds the lowest set mask bit at or above a starting index
`timescale 1ns/100ps
module iog_next_pick (
  input wire logic [8:0] mask,
  input wire logic [3:0] from,
  output logic found,
  output logic [3:0] idx
);

  ////////////////////////////////////////////////////////////////////////////
  // Scan downward so the lowest qualifying index is the last one kept
  always_comb
  begin
    found = 1'b0;
    idx = 4'h0;
    for (int i = 8; i >= 0; i--)
    begin
      if (mask[i] && (4'(i) >= from))
      begin
        found = 1'b1;
        idx = 4'(i);
      end
    end
  end
endmodule : iog_next_pick

//--- verilog/iog_dev_end.sv
// Device end: register file, conversion sequencer and pin drivers
// Notes on behaviour
// - bit 9 enables sequence repeat, reset zero
// - bit 8 adds temperature slot, reset zero
// - bits 7-0 include channels, none after reset
// - controller writes zero to sequence bits 15-10
// - output enable bit makes pin an output
// - push/pull output drives its data bit
// - open-drain drives low, releases on one
// - open-drain select bit per pin, default push/pull
// - output data register sets pin levels
// - data for non-output pins is ignored
// - input enable bit makes pin an input
// - controller selects readback pointer then reads
// - readback low byte holds input pin levels
// - float bit releases the pin, default off
// - controller writes pointer, high, low byte
// - controller writes zero upper config bytes
// - included channels convert in ascending order
// - new sequence restarts at its first channel
// - all sequence bits zero stops conversion
`timescale 1ns/100ps
`include "iog_defs.svh"
module iog_dev_end (
  input wire logic clk,
  input wire logic arst_n,
  iog_link_if.dev link,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic [7:0] io_oe_n,
  output logic conv_active,
  output logic [3:0] conv_channel
);

  ////////////////////////////////////////////////////////////////////////////
  // State and helper signals
  iog_pkg::iog_dev_state_type r_reg; // Registered state
  iog_pkg::iog_dev_state_type r_next; // Next state
  logic [15:0] wr_word; // Word formed by the byte now taken
  logic new_found; // New sequence has a slot
  logic [3:0] new_idx; // First slot of new sequence
  logic nxt_found; // Current sequence has a later slot
  logic [3:0] nxt_idx; // That later slot
  logic fst_found; // Current sequence has any slot
  logic [3:0] fst_idx; // First slot of current sequence
  logic [3:0] after_ch; // Index just past the current slot
  logic take_wr; // Write byte handshake
  logic take_rd; // Read byte handshake
  logic [15:0] rd_word; // Word selected by the pointer

  ////////////////////////////////////////////////////////////////////////////
  // Register read decode, used for both bytes of a read
  function automatic logic [15:0] reg_word(
    input iog_pkg::iog_dev_state_type s,
    input logic [7:0] pins
  );
    case (s.ptr)
      `IOG_PTR_SEQ: reg_word = s.seq;
      `IOG_PTR_LVL: reg_word = {8'h00, s.lvl};
      `IOG_PTR_OUT_EN: reg_word = {8'h00, s.out_en};
      `IOG_PTR_IN_EN: reg_word = {8'h00, s.in_en};
      `IOG_PTR_OD: reg_word = {8'h00, s.od};
      `IOG_PTR_FLT: reg_word = {8'h00, s.flt};
      `IOG_PTR_RDBACK: reg_word = {8'h00, pins & s.in_en};
      default: reg_word = 16'h0000;
    endcase
  endfunction : reg_word

  ////////////////////////////////////////////////////////////////////////////
  // Link handshakes and the word being completed
  assign wr_word = {r_reg.msb, link.wr_byte};
  assign link.wr_ready = r_reg.frame && !r_reg.rnw;
  assign take_wr = link.wr_ready && link.wr_valid;
  assign take_rd = r_reg.rvalid && link.rd_ready;
  assign link.rd_valid = r_reg.rvalid;
  assign link.rd_byte = r_reg.rbyte;
  assign rd_word = reg_word(r_reg, io_in);
  assign after_ch = r_reg.conv_ch + 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Slot finders: first slot of a word being written, next and first of the live one
  iog_next_pick u_pick_new (
    .mask(wr_word[8:0]),
    .from(4'h0),
    .found(new_found),
    .idx(new_idx)
  );

  iog_next_pick u_pick_nxt (
    .mask(r_reg.seq[8:0]),
    .from(after_ch),
    .found(nxt_found),
    .idx(nxt_idx)
  );

  iog_next_pick u_pick_fst (
    .mask(r_reg.seq[8:0]),
    .from(4'h0),
    .found(fst_found),
    .idx(fst_idx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    r_next = r_reg;

    // Conversion slot timer; a slot ends every conversion period
    if (r_reg.conv_on)
    begin
      if (r_reg.conv_cnt == `IOG_CONV_W'(`IOG_CONV_CYC - 1))
      begin
        r_next.conv_cnt = '0;
        if (nxt_found)
        begin
          r_next.conv_ch = nxt_idx;
        end
        else if (r_reg.seq[`IOG_SEQ_REP] && fst_found)
        begin
          r_next.conv_ch = fst_idx;
        end
        else
        begin
          // Without repeat the run stops and the last channel is kept
          r_next.conv_on = 1'b0;
        end
      end
      else
      begin
        r_next.conv_cnt = r_reg.conv_cnt + `IOG_CONV_W'(1);
      end
    end

    // Frame boundaries
    if (link.start)
    begin
      r_next.frame = 1'b1;
      r_next.rnw = link.start_rnw;
      r_next.wcnt = 2'd0;
      r_next.rsel = 1'b1;
      r_next.rvalid = link.start_rnw;
      r_next.rbyte = rd_word[15:8];
    end
    else if (link.stop)
    begin
      r_next.frame = 1'b0;
      r_next.rvalid = 1'b0;
    end
    else
    begin
      // Write bytes: pointer, high byte, then low byte commits
      if (take_wr)
      begin
        case (r_reg.wcnt)
          2'd0: r_next.ptr = link.wr_byte;
          2'd1: r_next.msb = link.wr_byte;
          2'd2:
          begin
            // Registers change only once the low byte is taken
            case (r_reg.ptr)
              `IOG_PTR_SEQ:
              begin
                r_next.seq = wr_word;
                r_next.conv_on = new_found;
                r_next.conv_ch = new_idx;
                r_next.conv_cnt = '0;
              end
              `IOG_PTR_OUT_EN: r_next.out_en = wr_word[7:0];
              `IOG_PTR_IN_EN: r_next.in_en = wr_word[7:0];
              `IOG_PTR_OD: r_next.od = wr_word[7:0];
              `IOG_PTR_LVL:
              begin
                // Bits of non-output pins keep their old value
                r_next.lvl = (wr_word[7:0] & r_reg.out_en) | (r_reg.lvl & ~r_reg.out_en);
              end
              `IOG_PTR_FLT: r_next.flt = wr_word[7:0];
              default: r_next.ptr = r_reg.ptr;
            endcase
          end
          default: r_next.wcnt = r_reg.wcnt;
        endcase
        if (r_reg.wcnt != 2'd3)
        begin
          r_next.wcnt = r_reg.wcnt + 2'd1;
        end
      end
      // Read bytes alternate high and low while the host keeps reading
      if (take_rd)
      begin
        r_next.rsel = !r_reg.rsel;
        r_next.rbyte = r_reg.rsel ? rd_word[7:0] : rd_word[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r_reg <= '0;
      r_reg.seq <= `IOG_REG_RST;
      r_reg.out_en <= `IOG_PIN_RST;
      r_reg.od <= `IOG_PIN_RST;
      r_reg.lvl <= `IOG_PIN_RST;
      r_reg.flt <= `IOG_PIN_RST;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers, one per pin; float wins, then output enable
  for (genvar g = 0; g < 8; g++)
  begin : g_pin
    logic drive; // Pin actively driven
    assign drive = !r_reg.flt[g] && r_reg.out_en[g] && !(r_reg.od[g] && r_reg.lvl[g]);
    assign io_oe_n[g] = !drive;
    assign io_out[g] = r_reg.lvl[g];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer status
  assign conv_active = r_reg.conv_on;
  assign conv_channel = r_reg.conv_ch;
endmodule : iog_dev_end

//--- verilog/iog_host_end.sv
// Host end: AXI4-Lite order registers driving link write and read frames
`timescale 1ns/100ps
`include "iog_defs.svh"
module iog_host_end (
  input wire logic clk,
  input wire logic arst_n,
  iog_link_if.host link,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  iog_pkg::iog_host_state_type r_reg; // Registered state
  iog_pkg::iog_host_state_type r_next; // Next state
  logic [31:0] ptr_merged; // Pointer after a lane-merged write
  logic [31:0] wdata_merged; // Data word after a lane-merged write

  // Byte-lane merge of a write into a held value
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] strb
  );
    for (int b = 0; b < 4; b++)
    begin
      lane_merge[b*8 +: 8] = strb[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
    end
  endfunction : lane_merge

  // Merged values for the two host registers that keep written data
  assign ptr_merged = lane_merge({24'h0, r_reg.ptr}, r_reg.wdat, r_reg.wstrb);
  assign wdata_merged = lane_merge({16'h0, r_reg.wdata}, r_reg.wdat, r_reg.wstrb);

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshakes and answers
  assign s_axi_awready = !r_reg.aw_got && !r_reg.bvalid;
  assign s_axi_wready = !r_reg.w_got && !r_reg.bvalid;
  assign s_axi_bvalid = r_reg.bvalid;
  assign s_axi_bresp = r_reg.bresp;
  assign s_axi_arready = !r_reg.rvalid;
  assign s_axi_rvalid = r_reg.rvalid;
  assign s_axi_rdata = r_reg.rdat;
  assign s_axi_rresp = r_reg.rresp;

  // Link strobes follow the sequencer state
  assign link.start = (r_reg.st == iog_pkg::H_START);
  assign link.start_rnw = r_reg.second;
  assign link.wr_valid = (r_reg.st == iog_pkg::H_SEND);
  assign link.wr_byte = r_reg.tx;
  assign link.rd_ready = (r_reg.st == iog_pkg::H_RECV);
  assign link.stop = (r_reg.st == iog_pkg::H_STOP);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    r_next = r_reg;
    // Bus write: address and data taken in either order
    if (r_reg.bvalid && s_axi_bready)
    begin
      r_next.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready)
    begin
      r_next.aw_got = 1'b1;
      r_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      r_next.w_got = 1'b1;
      r_next.wdat = s_axi_wdata;
      r_next.wstrb = s_axi_wstrb;
    end
    if (r_reg.aw_got && r_reg.w_got)
    begin
      r_next.aw_got = 1'b0;
      r_next.w_got = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = `IOG_RESP_OK;
      case (r_reg.awaddr)
        `IOG_AX_PTR: r_next.ptr = ptr_merged[7:0];
        `IOG_AX_WDATA: r_next.wdata = wdata_merged[15:0];
        `IOG_AX_GO:
        begin
          // An order while busy is dropped; write wins over read
          if (!r_reg.busy && r_reg.wstrb[0] && (r_reg.wdat[`IOG_GO_WR] || r_reg.wdat[`IOG_GO_RD]))
          begin
            r_next.busy = 1'b1;
            r_next.rd_op = !r_reg.wdat[`IOG_GO_WR];
            r_next.second = 1'b0;
            r_next.st = iog_pkg::H_START;
          end
        end
        `IOG_AX_STAT: r_next.bresp = `IOG_RESP_OK;
        default: r_next.bresp = `IOG_RESP_ERR;
      endcase
    end
    // Bus read
    if (r_reg.rvalid && s_axi_rready)
    begin
      r_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      r_next.rvalid = 1'b1;
      r_next.rresp = `IOG_RESP_OK;
      case (s_axi_araddr)
        `IOG_AX_PTR: r_next.rdat = {24'h0, r_reg.ptr};
        `IOG_AX_WDATA: r_next.rdat = {16'h0, r_reg.wdata};
        `IOG_AX_GO: r_next.rdat = 32'h0;
        `IOG_AX_STAT: r_next.rdat = {15'h0, r_reg.busy, r_reg.rdata};
        default:
        begin
          r_next.rdat = 32'h0;
          r_next.rresp = `IOG_RESP_ERR;
        end
      endcase
    end
    // Link sequencer
    case (r_reg.st)
      iog_pkg::H_IDLE:
      begin
        // Orders are launched by the GO decode above; its next state is kept
        r_next.idx = 2'd0;
      end
      iog_pkg::H_START:
      begin
        r_next.idx = 2'd0;
        r_next.tx = r_reg.ptr;
        r_next.st = r_reg.second ? iog_pkg::H_RECV : iog_pkg::H_SEND;
      end
      iog_pkg::H_SEND:
      begin
        // Pointer, high byte, low byte; a read sends the pointer only
        if (link.wr_ready)
        begin
          r_next.idx = r_reg.idx + 2'd1;
          if (!r_reg.rd_op && r_reg.idx == 2'd0)
          begin
            r_next.tx = r_reg.wdata[15:8];
          end
          else if (!r_reg.rd_op && r_reg.idx == 2'd1)
          begin
            r_next.tx = r_reg.wdata[7:0];
          end
          else
          begin
            r_next.st = iog_pkg::H_STOP;
          end
        end
      end
      iog_pkg::H_RECV:
      begin
        if (link.rd_valid)
        begin
          r_next.idx = r_reg.idx + 2'd1;
          if (r_reg.idx == 2'd0)
          begin
            r_next.rdata[15:8] = link.rd_byte;
          end
          else
          begin
            r_next.rdata[7:0] = link.rd_byte;
            r_next.st = iog_pkg::H_STOP;
          end
        end
      end
      iog_pkg::H_STOP:
      begin
        if (r_reg.rd_op && !r_reg.second)
        begin
          r_next.second = 1'b1;
          r_next.st = iog_pkg::H_START;
        end
        else
        begin
          r_next.busy = 1'b0;
          r_next.st = iog_pkg::H_IDLE;
        end
      end
      default: r_next.st = iog_pkg::H_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r_reg <= '0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end
endmodule : iog_host_end

//--- dv/iog_link_sva.sv
// Protocol checker for the byte link between host end and device end
`timescale 1ns/100ps
module iog_link_sva (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic start_rnw,
  input wire logic wr_valid,
  input wire logic [7:0] wr_byte,
  input wire logic wr_ready,
  input wire logic rd_valid,
  input wire logic [7:0] rd_byte,
  input wire logic rd_ready,
  input wire logic stop
);
  // All checks run on the one clock and stop during reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////
  // Frame framing
  start_one_cycle_a: assert property (start |=> !start && !stop)
    else $error("start pulse not single");
  stop_one_cycle_a: assert property (stop |=> !stop && !wr_valid && !rd_ready)
    else $error("stop pulse not single");
  wr_open_a: assert property (start && !start_rnw |=> wr_ready && wr_valid)
    else $error("write frame did not open with pointer byte");
  rd_open_a: assert property (start && start_rnw |=> rd_valid && !wr_ready)
    else $error("read frame gave no byte");
  frame_close_a: assert property (stop |=> !rd_valid && !wr_ready)
    else $error("frame still open after stop");

  ////////////////////////////////////////////////////////////////////////
  // Byte hand-over
  wr_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_byte))
    else $error("write byte dropped before taken");
  rd_hold_a: assert property (rd_valid && !rd_ready && !stop |=> $stable(rd_byte))
    else $error("read byte changed before taken");
  rd_stays_a: assert property (rd_valid && !stop |=> rd_valid)
    else $error("read byte withdrawn inside frame");

  // Main traffic kinds
  wr_frame_c: cover property (start && !start_rnw ##1 wr_valid [*3] ##1 stop);
  rd_frame_c: cover property (start && start_rnw ##1 rd_valid && rd_ready);
  rd_two_c: cover property (rd_valid && rd_ready ##1 rd_valid && rd_ready ##1 stop);
endmodule : iog_link_sva

//--- dv/io_gpio_adc_sequence_config_tb.sv
// Testbench: host end and device end joined over the link, driven over AXI4-Lite
`timescale 1ns/100ps
`include "iog_defs.svh"
module io_gpio_adc_sequence_config_tb;
  logic clk = 1'b0; // 10 MHz clock
  logic arst_n = 1'b0; // Reset, active low
  logic [3:0] s_axi_awaddr = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [7:0] ext_lvl = 8'hff; // Outside drive, pull-up where released
  logic [7:0] io_in; // Resolved pin levels
  logic [7:0] io_out;
  logic [7:0] io_oe_n;
  logic conv_active;
  logic [3:0] conv_channel;
  int err_total = 0; // Mismatches
  int checked = 0; // Comparisons

  always #50 clk = ~clk;

  // Pin is what the device drives, else the outside level
  assign io_in = (~io_oe_n & io_out) | (io_oe_n & ext_lvl);

  iog_link_if link ();
  iog_host_end u_iog_host_end (.clk(clk), .arst_n(arst_n), .link(link),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  iog_dev_end u_iog_dev_end (.clk(clk), .arst_n(arst_n), .link(link), .io_in(io_in),
    .io_out(io_out), .io_oe_n(io_oe_n), .conv_active(conv_active),
    .conv_channel(conv_channel));
  iog_link_sva u_iog_link_sva (.clk(clk), .arst_n(arst_n), .start(link.start),
    .start_rnw(link.start_rnw), .wr_valid(link.wr_valid), .wr_byte(link.wr_byte),
    .wr_ready(link.wr_ready), .rd_valid(link.rd_valid), .rd_byte(link.rd_byte),
    .rd_ready(link.rd_ready), .stop(link.stop));

  ////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Counts, verdict and end of run
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write; ready is sampled in the low phase, acted on at the edge
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_t;
    logic w_t;
    logic b_t;
    b_t = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_t)
    begin
      @(negedge clk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = (s_axi_bvalid === 1'b1);
      r = s_axi_bresp;
      @(posedge clk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      if (b_t) s_axi_bready <= 1'b0;
    end
  endtask : axi_write

  // AXI4-Lite read, answer taken at the edge where rready meets rvalid
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t;
    logic r_t;
    r_t = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_t)
    begin
      @(negedge clk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = (s_axi_rvalid === 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ar_t) s_axi_arvalid <= 1'b0;
      if (r_t) s_axi_rready <= 1'b0;
    end
  endtask : axi_read

  // Start an order and poll the status word until it is no longer busy
  task automatic dev_go(input logic [31:0] go, output logic [15:0] w);
    logic [31:0] st;
    logic [1:0] r;
    axi_write(`IOG_AX_GO, go, r);
    st = 32'h0001_0000;
    while (st[16] === 1'b1) axi_read(`IOG_AX_STAT, st, r);
    w = st[15:0];
    @(negedge clk);
  endtask : dev_go

  // Full register write frame: pointer, high byte, low byte
  task automatic dev_write(input logic [7:0] p, input logic [15:0] v);
    logic [1:0] r;
    logic [15:0] junk;
    axi_write(`IOG_AX_PTR, {24'h0, p}, r);
    axi_write(`IOG_AX_WDATA, {16'h0, v}, r);
    dev_go(32'h1, junk);
  endtask : dev_write

  // Pointer frame then two-byte read frame
  task automatic dev_read(input logic [7:0] p, output logic [15:0] v);
    logic [1:0] r;
    axi_write(`IOG_AX_PTR, {24'h0, p}, r);
    dev_go(32'h2, v);
  endtask : dev_read

  // Wait a bounded time for a conversion slot
  task automatic wait_ch(input logic [3:0] ch);
    int n;
    n = 0;
    @(negedge clk);
    while (conv_channel !== ch && n < 25)
    begin
      @(negedge clk);
      n++;
    end
    chk({12'h0, conv_channel}, {12'h0, ch});
  endtask : wait_ch

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [7:0] ptrs [6];
    logic [15:0] w;
    logic [31:0] d;
    logic [1:0] r;
    ptrs = '{`IOG_PTR_SEQ, `IOG_PTR_OUT_EN, `IOG_PTR_OD, `IOG_PTR_LVL, `IOG_PTR_FLT,
      `IOG_PTR_IN_EN};
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    chk({8'h0, io_oe_n}, 16'h00ff);
    chk({8'h0, io_out}, 16'h0000);
    chk({15'h0, conv_active}, 16'h0000);
    // Reset values of every device register
    foreach (ptrs[i])
    begin
      dev_read(ptrs[i], w);
      chk(w, `IOG_REG_RST);
    end
    // Unmapped host offsets are refused
    axi_write(4'h2, 32'h0, r);
    chk({14'h0, r}, {14'h0, `IOG_RESP_ERR});
    axi_read(4'h6, d, r);
    chk({14'h0, r}, {14'h0, `IOG_RESP_ERR});
    // Outputs on low pins; levels for other pins are dropped
    dev_write(`IOG_PTR_OUT_EN, 16'h000f);
    dev_write(`IOG_PTR_LVL, 16'h00ff);
    chk({8'h0, io_out}, 16'h000f);
    chk({8'h0, io_oe_n}, 16'h00f0);
    dev_read(`IOG_PTR_LVL, w);
    chk(w, 16'h000f);
    // Open-drain on pins 0 and 1: released while high, driven while low
    dev_write(`IOG_PTR_OD, 16'h0003);
    chk({8'h0, io_oe_n}, 16'h00f3);
    dev_write(`IOG_PTR_LVL, 16'h0005);
    chk({8'h0, io_out}, 16'h0005);
    chk({8'h0, io_oe_n}, 16'h00f1);
    // Float pin 2 overrides its output enable
    dev_write(`IOG_PTR_FLT, 16'h0004);
    chk({8'h0, io_oe_n}, 16'h00f5);
    // Input readback sees resolved pin levels of input pins only
    dev_write(`IOG_PTR_IN_EN, 16'h0033);
    dev_read(`IOG_PTR_RDBACK, w);
    chk(w, 16'h0031);
    ext_lvl <= 8'h00;
    dev_read(`IOG_PTR_RDBACK, w);
    chk(w, 16'h0000);
    // Repeating sequence of channels 0 and 7
    dev_write(`IOG_PTR_SEQ, 16'h0281);
    chk({15'h0, conv_active}, 16'h0001);
    chk({12'h0, conv_channel}, 16'h0000);
    wait_ch(4'h7);
    wait_ch(4'h0);
    // New sequence restarts at its first slot; temperature slot comes last
    dev_write(`IOG_PTR_SEQ, 16'h0104);
    chk({12'h0, conv_channel}, 16'h0002);
    wait_ch(`IOG_TEMP_IDX);
    repeat (22) @(negedge clk);
    chk({15'h0, conv_active}, 16'h0000);
    chk({12'h0, conv_channel}, {12'h0, `IOG_TEMP_IDX});
    dev_read(`IOG_PTR_SEQ, w);
    chk(w, 16'h0104);
    // Clearing every sequence bit stops a repeating run
    dev_write(`IOG_PTR_SEQ, 16'h0281);
    dev_write(`IOG_PTR_SEQ, 16'h0000);
    chk({15'h0, conv_active}, 16'h0000);
    finish_test();
  end

  // Watchdog against a hung handshake
  initial
  begin
    #5_000_000;
    err_total++;
    $display("mismatch at %0t: run timed out", $time);
    finish_test();
  end
endmodule : io_gpio_adc_sequence_config_tb
